// ### rtl/gdpc_delayed_pulse.sv
`timescale 1ns/1ps
module gdpc_delayed_pulse (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Software commands, one-cycle pulses
    input wire logic arm_cmd,
    input wire logic disarm_cmd,
    input wire logic load_cmd,
    // Counter mode configuration
    input wire logic cfg_gate_edge,
    input wire logic cfg_count_up,
    // Count registers
    input wire logic [15:0] load_value,
    input wire logic [15:0] hold_value,
    // External pins
    input wire logic src_pin,
    input wire logic gate_pin,
    // Status
    output logic armed,
    output logic triggered,
    output logic pulse_phase,
    output logic terminal_count,
    output logic [15:0] count_value
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_GATE,
        ST_DELAY,
        ST_WIDTH
    } gdpc_state_e;

    typedef struct packed {
        gdpc_state_e state;
        logic src_d;
        logic gate_d;
        logic tc;
        logic [15:0] cnt;
    } gdpc_core_s;

    gdpc_core_s st_ff;
    gdpc_core_s nxt_st;
    logic [1:0] pin_raw;
    logic [1:0] pin_lvl;
    logic src_lvl;
    logic gate_lvl;
    logic src_rise;
    logic gate_rise;
    logic at_tc;
    logic qualified;
    logic level_mode;
    logic in_count;
    logic in_delay;
    logic arm_take;
    logic load_take;
    logic disarm_take;
    logic [15:0] cnt_step;
    logic [15:0] cnt_next;
    logic [15:0] reload_value;

    // Both external pins, gate above source
    assign pin_raw = {gate_pin, src_pin};

    // One synchroniser per external pin
    for (genvar p = 0; p < $bits(pin_raw); p++) begin : g_pin_sync
        gdpc_sync u_sync (
            .clk_sys(clk_sys),
            .srst(srst),
            .pin_in(pin_raw[p]),
            .level_out(pin_lvl[p])
        );
    end

    // Clean levels by name
    assign {gate_lvl, src_lvl} = pin_lvl;

    // Edge detection; history idles low, as the gate does
    assign src_rise = src_lvl & ~st_ff.src_d;
    assign gate_rise = gate_lvl & ~st_ff.gate_d;

    // Gating field of the mode configuration
    assign level_mode = (cfg_gate_edge == gdpc_pkg::GATE_LEVEL);

    // Phase decode of the current state
    assign in_count = (st_ff.state == ST_DELAY) || (st_ff.state == ST_WIDTH);
    assign in_delay = (st_ff.state == ST_DELAY);

    // Commands; arm and load only taken while disarmed
    assign arm_take = arm_cmd && (st_ff.state == ST_IDLE);
    assign load_take = load_cmd && (st_ff.state == ST_IDLE);
    assign disarm_take = disarm_cmd && (st_ff.state != ST_IDLE);

    // Terminal count point for the current direction
    always_comb begin
        if (cfg_count_up) begin
            at_tc = (st_ff.cnt == gdpc_pkg::CNT_ALL);
        end else begin
            at_tc = (st_ff.cnt == gdpc_pkg::CNT_ONE);
        end
    end

    // One count step in the chosen direction
    always_comb begin
        if (cfg_count_up) begin
            cnt_step = st_ff.cnt + gdpc_pkg::CNT_ONE;
        end else begin
            cnt_step = st_ff.cnt - gdpc_pkg::CNT_ONE;
        end
    end

    // Reload source: hold ends the delay, load ends the width
    always_comb begin
        if (in_delay) begin
            reload_value = hold_value;
        end else begin
            reload_value = load_value;
        end
    end

    // Counter value after a qualified edge
    always_comb begin
        if (at_tc) begin
            cnt_next = reload_value;
        end else begin
            cnt_next = cnt_step;
        end
    end

    // Which source edges count in the active phases
    always_comb begin
        if (level_mode) begin
            qualified = src_rise & gate_lvl;
        end else begin
            qualified = src_rise;
        end
    end

    // Sequencer; only the active phases count, the idle state takes loads
    always_comb begin
        nxt_st = st_ff;
        nxt_st.src_d = src_lvl;
        nxt_st.gate_d = gate_lvl;
        nxt_st.tc = 1'b0;
        case (st_ff.state)
            ST_IDLE: begin
                // Disarmed: no counting, gate edges dropped
                if (load_take) begin
                    nxt_st.cnt = load_value;
                end
                if (arm_take) begin
                    if (level_mode) begin
                        nxt_st.state = ST_DELAY;
                    end else begin
                        nxt_st.state = ST_WAIT_GATE;
                    end
                end
            end
            ST_WAIT_GATE: begin
                // Source edge of the trigger cycle is not counted
                if (gate_rise) begin
                    nxt_st.state = ST_DELAY;
                end
            end
            ST_DELAY: begin
                // Delay phase, started from the load value
                if (qualified) begin
                    nxt_st.cnt = cnt_next;
                    if (at_tc) begin
                        nxt_st.tc = 1'b1;
                        nxt_st.state = ST_WIDTH;
                    end
                end
            end
            ST_WIDTH: begin
                // Width phase, started from the hold value
                if (qualified) begin
                    nxt_st.cnt = cnt_next;
                    if (at_tc) begin
                        nxt_st.tc = 1'b1;
                        nxt_st.state = ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_st.state = ST_IDLE;
            end
        endcase
        // Disarm command overrides any armed state
        if (disarm_take) begin
            nxt_st.state = ST_IDLE;
        end
    end

    // State register; disarmed with a cleared counter
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_ff <= '{
                state: ST_IDLE,
                src_d: 1'b0,
                gate_d: 1'b0,
                tc: 1'b0,
                cnt: gdpc_pkg::CNT_RST
            };
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Status outputs straight from the state register
    assign armed = (st_ff.state != ST_IDLE);
    assign triggered = in_count;
    assign pulse_phase = (st_ff.state == ST_WIDTH);
    assign terminal_count = st_ff.tc;
    assign count_value = st_ff.cnt;
endmodule

// ### include/gdpc_pkg.sv
package gdpc_pkg;
    localparam int unsigned CNT_W = 16;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_ALL = 16'hffff;
    localparam logic [15:0] CNT_RST = 16'h0000;
    // Gating field of counter_mode_config
    localparam logic GATE_LEVEL = 1'h0;
    localparam logic GATE_EDGE = 1'h1;
    localparam logic [2:0] SYNC_RST = 3'h0;
endpackage

// ### rtl/gdpc_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; output changes once stages two and three agree
module gdpc_sync (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Pin in, clean level out
    input wire logic pin_in,
    output logic level_out
);
    typedef struct packed {
        logic [2:0] stg;
        logic level;
    } gdpc_sync_s;

    gdpc_sync_s st_ff;
    gdpc_sync_s nxt_st;

    // Shift and agree
    always_comb begin
        nxt_st = st_ff;
        nxt_st.stg = {st_ff.stg[1:0], pin_in};
        if (st_ff.stg[1] == st_ff.stg[2]) begin
            nxt_st.level = st_ff.stg[2];
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_ff <= '{stg: gdpc_pkg::SYNC_RST, level: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign level_out = st_ff.level;
endmodule

// ### verification/gdpc_monitor.sv
`timescale 1ns/1ps
// Port checks of the delayed-pulse counter
module gdpc_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Commands and mode
    input wire logic arm_cmd,
    input wire logic disarm_cmd,
    input wire logic load_cmd,
    input wire logic cfg_gate_edge,
    input wire logic cfg_count_up,
    // Count registers and gate pin
    input wire logic [15:0] load_value,
    input wire logic [15:0] hold_value,
    input wire logic gate_pin,
    // Status
    input wire logic armed,
    input wire logic triggered,
    input wire logic pulse_phase,
    input wire logic terminal_count,
    input wire logic [15:0] count_value
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_arm_taken: assert property (arm_cmd && !armed && !disarm_cmd
        |=> armed) else $error("arm lost");
    a_first_reload: assert property ($rose(pulse_phase) |->
        terminal_count && count_value == hold_value) else $error("hold");
    a_last_reload: assert property ($fell(armed) && !$past(disarm_cmd)
        |-> terminal_count && count_value == load_value) else $error("ld");
    a_idle_hold: assert property (!armed && !$past(armed)
        && !$past(load_cmd) |-> $stable(count_value)) else $error("idle");
    a_edge_wait: assert property (cfg_gate_edge && !$past(triggered)
        && $past(armed) |-> $stable(count_value)) else $error("early");
    a_gate_pause: assert property ((!gate_pin)[*8] ##0 (!cfg_gate_edge
        && $past(armed)) |-> $stable(count_value)) else $error("gate");
    a_step_one: assert property ($past(armed) && !terminal_count
        && $changed(count_value) |-> count_value == $past(count_value)
        + (cfg_count_up ? 16'h0001 : 16'hffff)) else $error("step");
    a_tc_point: assert property (terminal_count |-> $past(count_value)
        == (cfg_count_up ? gdpc_pkg::CNT_ALL : gdpc_pkg::CNT_ONE)
        ##1 !terminal_count) else $error("tc");
    // Source pulses every 8 cycles; gate changes must not stall
    a_gate_ignored: assert property (cfg_gate_edge && triggered
        |-> ##[1:10] (terminal_count || $changed(count_value) || !triggered))
        else $error("stall");
endmodule
bind gdpc_delayed_pulse gdpc_monitor i_mon (.*);

// ### verification/gdpc_pins.sv
`timescale 1ns/1ps
// Far side: source pulses every 8 cycles, gate as asked
module gdpc_pins (
    // Clock and gate request
    input wire logic clk_sys,
    input wire logic gate_req,
    // Pins
    output logic src_pin,
    output logic gate_pin = 1'b0
);
    logic [2:0] ph_ff = 3'h0;
    // Pins change off clean edges, source high and low 4 cycles
    always @(posedge clk_sys) begin
        ph_ff <= ph_ff + 3'h1;
        gate_pin <= gate_req;
    end
    assign src_pin = ph_ff[2];
endmodule

// ### verification/tb_gated_delayed_pulse_counter.sv
`timescale 1ns/1ps
module tb_gated_delayed_pulse_counter;
    logic clk_sys = 0, srst = 1, arm_cmd = 0, disarm_cmd = 0, load_cmd = 0;
    logic cfg_gate_edge = 0, cfg_count_up = 0, gate_req = 0;
    logic src_pin, gate_pin, armed, triggered, pulse_phase, terminal_count;
    logic [15:0] load_value = 16'h0, hold_value = 16'h0, count_value, ld, hd;
    logic [15:0] q[$];
    logic [31:0] r = 32'h2121;
    int fail_count = 0, samples_checked = 0, cyc = 0;
    gdpc_delayed_pulse i_dut (.*);
    gdpc_pins i_pins (.*);
    initial forever #50 clk_sys = ~clk_sys;
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input string nm, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task close_out;
        $display("checks %0d fails %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #10;
    endtask
    // Watch reloads against the noted order; cut a hang
    always @(negedge clk_sys) begin
        cyc++;
        if (terminal_count === 1'b1)
            check("reload", count_value, q.size() ? q.pop_front() : 'x);
        if (cyc > 30000) begin
            fail_count++;
            close_out();
        end
    end
    // One delayed-pulse sequence in the given mode
    task run(input logic e, u);
        r = lfsr(r);
        ld = u ? 16'hfffc | r[1:0] : 16'h0001 + r[1:0];
        hd = u ? 16'hfffc | r[3:2] : 16'h0001 + r[3:2];
        {cfg_gate_edge, cfg_count_up} = {e, u};
        {load_value, hold_value} = {ld, hd};
        gate_req = 1;
        tick(8);
        gate_req = 0;
        load_cmd = 1;
        tick(8);
        load_cmd = 0;
        arm_cmd = 1;
        tick(1);
        arm_cmd = 0;
        q.push_back(hd);
        q.push_back(ld);
        tick(20);
        check("trig", 16'(triggered), 16'(!e));
        gate_req = 1;
        for (int n = 0; n < 3000 && armed === 1'b1; n++) begin
            r = lfsr(r);
            if (n % 8 == 7) gate_req = r[0];
            tick(1);
        end
        check("armed", 16'(armed), 16'h0);
        check("count", count_value, ld);
        gate_req = 0;
        tick(8);
    endtask
    // Edge mode: load refused while armed, disarm, gate then ignored
    task hold_off;
        r = lfsr(r);
        ld = 16'h0001 + r[1:0];
        {cfg_gate_edge, cfg_count_up} = 2'h2;
        load_value = ld;
        load_cmd = 1;
        tick(1);
        load_cmd = 0;
        arm_cmd = 1;
        tick(1);
        arm_cmd = 0;
        load_value = ~ld;
        load_cmd = 1;
        tick(1);
        load_cmd = 0;
        tick(20);
        check("wait", count_value, ld);
        disarm_cmd = 1;
        tick(1);
        disarm_cmd = 0;
        check("disarm", 16'(armed), 16'h0);
        gate_req = 1;
        tick(20);
        check("gate", 16'(triggered), 16'h0);
        check("idle", count_value, ld);
        gate_req = 0;
        tick(8);
    endtask
    initial begin
        tick(5);
        srst = 0;
        tick(4);
        for (int m = 0; m < 8; m++) run(m[0], m[1]);
        hold_off();
        close_out();
    end
endmodule
